/* bce_exec.sv */
// Purpose: executes return, rotates, power-down, subtract, nibble swap,
//          direction load and literal xor of a baseline 8-bit core
// Assumes: decoder offers one instruction with INSTR_VALID while READY
//          is high; FILE_RDATA holds the addressed register that cycle
// Notes:   all outputs are flops; results appear one cycle after taking
// What this block does
// - return loads program counter from stack top
// - return occupies two instruction cycles
// - rotate left through carry, only carry
// - rotate right through carry, only carry
// - destination bit picks accumulator or file
// - power-down clears watchdog counter and prescaler
// - power-down sets timeout, clears powerdown, keeps wakeup
// - power-down stops oscillator until wake-up
// - subtract file minus accumulator, updates three flags
// - nibble swap of file, no flags
// - direction load from accumulator, selections 6-8
// - xor literal into accumulator, updates zero
// - file operand five bits plus destination bit
module bce_exec
  import bce_pkg::*;
#(
  parameter int PC_W  = 11,
  parameter int PRE_W = 8
)
(
  input  wire logic               CORE_CLK,
  input  wire logic               RESET_N,
  input  wire logic               CLK_EN,
  input  wire logic               INSTR_VALID,
  input  wire bce_instr_t         INSTR,
  input  wire logic [DATA_W-1:0]  FILE_RDATA,
  input  wire logic [PC_W-1:0]    STACK_TOP,
  input  wire logic               WDT_TICK,
  input  wire logic               WAKE,
  input  wire logic [RADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0]  REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output logic [DATA_W-1:0]       REG_RDATA,
  output logic                    READY,
  output logic                    PC_LOAD,
  output logic [PC_W-1:0]         PC_VALUE,
  output logic                    STACK_POP,
  output logic                    FILE_WE,
  output logic [FILE_W-1:0]       FILE_WADDR,
  output logic [DATA_W-1:0]       FILE_WDATA,
  output logic                    OSC_STOP,
  output logic [DATA_W-1:0]       DIR0,
  output logic [DATA_W-1:0]       DIR1,
  output logic [DATA_W-1:0]       DIR2
);

  typedef struct packed {
    logic [DATA_W-1:0]      acc;
    logic                   carry;
    logic                   digit_carry_flag;
    logic                   zero;
    logic                   timeout_status_bit;
    logic                   powerdown_status_bit;
    logic                   port_wakeup_flag;
    logic [2:0][DATA_W-1:0] dir;
    logic [DATA_W-1:0]      watchdog_counter;
    logic [PRE_W-1:0]       prescaler;
    logic                   busy;
    logic                   sleeping;
    logic                   ready;
    logic                   pc_load;
    logic [PC_W-1:0]        program_counter;
    logic                   stack_pop;
    logic                   file_we;
    logic [FILE_W-1:0]      file_waddr;
    logic [DATA_W-1:0]      file_wdata;
    logic [DATA_W-1:0]      rdata;
  } bce_state_t;

  bce_state_t s_q;
  bce_state_t s_d;
  bce_alu_t   alu;
  logic       take;
  logic [DATA_W-1:0] status_view;
  logic [DATA_W-1:0] read_mux;

  bce_alu u_alu (
    .op       (INSTR.op),
    .file_val (FILE_RDATA),
    .acc      (s_q.acc),
    .lit      (INSTR.lit),
    .carry_in (s_q.carry),
    .res      (alu)
  );

  // an instruction is taken only while the core is ready
  assign take = INSTR_VALID && s_q.ready;

  always_comb
  begin
    status_view = '0;
    status_view[ST_C]     = s_q.carry;
    status_view[ST_DIGIT] = s_q.digit_carry_flag;
    status_view[ST_Z]     = s_q.zero;
    status_view[ST_PWRDN] = s_q.powerdown_status_bit;
    status_view[ST_TMOUT] = s_q.timeout_status_bit;
    status_view[ST_WUF]   = s_q.port_wakeup_flag;
  end

  always_comb
  begin
    unique case (REG_ADDR)
      OFS_ACC:    read_mux = s_q.acc;
      OFS_STATUS: read_mux = status_view;
      OFS_WDOG:   read_mux = s_q.watchdog_counter;
      OFS_PRE:    read_mux = DATA_W'(s_q.prescaler);
      OFS_DIR0:   read_mux = s_q.dir[0];
      OFS_DIR1:   read_mux = s_q.dir[1];
      OFS_DIR2:   read_mux = s_q.dir[2];
      OFS_RUN:    read_mux = {5'h00, s_q.busy, s_q.sleeping, s_q.ready};
      default:    read_mux = '0;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.pc_load   = 1'b0;
    s_d.stack_pop = 1'b0;
    s_d.file_we   = 1'b0;
    s_d.busy      = 1'b0;
    s_d.rdata     = REG_RD ? read_mux : '0;

    // software writes; instruction effects below take precedence
    if (REG_WR)
    begin
      unique case (REG_ADDR)
        OFS_ACC: s_d.acc = REG_WDATA;
        OFS_STATUS:
        begin
          s_d.carry            = REG_WDATA[ST_C];
          s_d.digit_carry_flag = REG_WDATA[ST_DIGIT];
          s_d.zero             = REG_WDATA[ST_Z];
          s_d.port_wakeup_flag = REG_WDATA[ST_WUF];
        end
        default: ;
      endcase
    end

    // watchdog keeps running on its own tick, even asleep
    if (WDT_TICK)
    begin
      s_d.prescaler = s_q.prescaler + PRE_W'(1);
      if (s_q.prescaler == '1)
        s_d.watchdog_counter = s_q.watchdog_counter + 8'h01;
    end

    // wake-up source ends sleep; set beats a software clear
    if (s_q.sleeping && WAKE)
    begin
      s_d.sleeping         = 1'b0;
      s_d.port_wakeup_flag = 1'b1;
    end

    if (take)
    begin
      unique case (INSTR.op)
        return_op:
        begin
          s_d.pc_load         = 1'b1;
          s_d.program_counter = STACK_TOP;
          s_d.stack_pop       = 1'b1;
          s_d.busy            = 1'b1;
        end
        powerdown_op:
        begin
          s_d.watchdog_counter     = RST_WDOG;
          s_d.prescaler            = '0;
          s_d.timeout_status_bit   = 1'b1;
          s_d.powerdown_status_bit = 1'b0;
          s_d.port_wakeup_flag     = s_q.port_wakeup_flag;
          s_d.sleeping             = 1'b1;
        end
        direction_load_op:
        begin
          unique case (INSTR.file)
            DIR_SEL_FIRST:  s_d.dir[0] = s_q.acc;
            DIR_SEL_SECOND: s_d.dir[1] = s_q.acc;
            DIR_SEL_THIRD:  s_d.dir[2] = s_q.acc;
            default: ;
          endcase
        end
        xor_literal_acc_op:
          s_d.acc = alu.result;
        rotate_left_carry_op, rotate_right_carry_op,
        subtract_acc_from_file_op, nibble_exchange_op:
        begin
          if (INSTR.dest == DEST_FILE)
          begin
            s_d.file_we    = 1'b1;
            s_d.file_waddr = INSTR.file;
            s_d.file_wdata = alu.result;
          end
          else
            s_d.acc = alu.result;
        end
      endcase
      if (alu.upd_carry)
        s_d.carry = alu.carry;
      if (alu.upd_dc)
        s_d.digit_carry_flag = alu.digit_carry_flag;
      if (alu.upd_zero)
        s_d.zero = alu.zero;
    end

    // single-cycle ops keep ready high; return and sleep drop it
    s_d.ready = !s_d.busy && !s_d.sleeping;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s_q                      <= '0;
      s_q.acc                  <= RST_ACC;
      s_q.timeout_status_bit   <= RST_TMOUT;
      s_q.powerdown_status_bit <= RST_PWRDN;
      s_q.dir                  <= {3{RST_DIR}};
      s_q.watchdog_counter     <= RST_WDOG;
      s_q.ready                <= 1'b1;
    end
    else if (CLK_EN)
      s_q <= s_d;
  end

  assign REG_RDATA  = s_q.rdata;
  assign READY      = s_q.ready;
  assign PC_LOAD    = s_q.pc_load;
  assign PC_VALUE   = s_q.program_counter;
  assign STACK_POP  = s_q.stack_pop;
  assign FILE_WE    = s_q.file_we;
  assign FILE_WADDR = s_q.file_waddr;
  assign FILE_WDATA = s_q.file_wdata;
  assign OSC_STOP   = s_q.sleeping;
  assign DIR0       = s_q.dir[0];
  assign DIR1       = s_q.dir[1];
  assign DIR2       = s_q.dir[2];

endmodule : bce_exec

/* bce_pkg.sv */
// Purpose: shared types and constants of the instruction execution unit
// Assumes: 8-bit data path, 5-bit file addresses, 3-bit opcode field
// Notes:   register map sits on the plain software port of bce_exec
package bce_pkg;

  localparam int DATA_W = 8;
  localparam int FILE_W = 5;
  localparam int RADDR_W = 4;

  // opcode encodings of the executed group
  typedef enum logic [2:0] {
    return_op                 = 3'b000,
    rotate_left_carry_op      = 3'b001,
    rotate_right_carry_op     = 3'b010,
    powerdown_op              = 3'b011,
    subtract_acc_from_file_op = 3'b100,
    nibble_exchange_op        = 3'b101,
    direction_load_op         = 3'b110,
    xor_literal_acc_op        = 3'b111
  } bce_op_t;

  typedef struct packed {
    bce_op_t            op;
    logic [FILE_W-1:0]  file;
    logic               dest;
    logic [DATA_W-1:0]  lit;
  } bce_instr_t;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic              carry;
    logic              digit_carry_flag;
    logic              zero;
    logic              upd_carry;
    logic              upd_dc;
    logic              upd_zero;
  } bce_alu_t;

  // destination select values
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // direction register selections
  localparam logic [FILE_W-1:0] DIR_SEL_FIRST  = 5'h06;
  localparam logic [FILE_W-1:0] DIR_SEL_SECOND = 5'h07;
  localparam logic [FILE_W-1:0] DIR_SEL_THIRD  = 5'h08;

  // software register offsets
  localparam logic [RADDR_W-1:0] OFS_ACC    = 4'h0;
  localparam logic [RADDR_W-1:0] OFS_STATUS = 4'h1;
  localparam logic [RADDR_W-1:0] OFS_WDOG   = 4'h2;
  localparam logic [RADDR_W-1:0] OFS_PRE    = 4'h3;
  localparam logic [RADDR_W-1:0] OFS_DIR0   = 4'h4;
  localparam logic [RADDR_W-1:0] OFS_DIR1   = 4'h5;
  localparam logic [RADDR_W-1:0] OFS_DIR2   = 4'h6;
  localparam logic [RADDR_W-1:0] OFS_RUN    = 4'h7;

  // status register field positions
  localparam int ST_C     = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_Z     = 2;
  localparam int ST_PWRDN = 3;
  localparam int ST_TMOUT = 4;
  localparam int ST_WUF   = 7;

  // reset values
  localparam logic [DATA_W-1:0] RST_ACC   = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIR   = 8'hff;
  localparam logic              RST_TMOUT = 1'b1;
  localparam logic              RST_PWRDN = 1'b1;
  localparam logic [DATA_W-1:0] RST_WDOG  = 8'h00;

endpackage : bce_pkg

/* bce_alu.sv */
// Purpose: combinational result and flag logic of the data operations
// Assumes: operands stable in the cycle the instruction is taken
// Notes:   return, power-down and direction load produce no result
module bce_alu
  import bce_pkg::*;
(
  input  wire bce_op_t           op,
  input  wire logic [DATA_W-1:0] file_val,
  input  wire logic [DATA_W-1:0] acc,
  input  wire logic [DATA_W-1:0] lit,
  input  wire logic              carry_in,
  output bce_alu_t               res
);

  logic [DATA_W:0] diff;
  logic [4:0]      low_diff;

  // f - w as f + ~w + 1, carry set means no borrow
  assign diff = {1'b0, file_val} + {1'b0, ~acc} + 9'h001;
  assign low_diff = {1'b0, file_val[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

  always_comb
  begin
    res = '0;
    unique case (op)
      rotate_left_carry_op:
      begin
        res.result    = {file_val[6:0], carry_in};
        res.carry     = file_val[7];
        res.upd_carry = 1'b1;
      end
      rotate_right_carry_op:
      begin
        res.result    = {carry_in, file_val[7:1]};
        res.carry     = file_val[0];
        res.upd_carry = 1'b1;
      end
      subtract_acc_from_file_op:
      begin
        res.result           = diff[DATA_W-1:0];
        res.carry            = diff[DATA_W];
        res.digit_carry_flag = low_diff[4];
        res.upd_carry        = 1'b1;
        res.upd_dc           = 1'b1;
        res.upd_zero         = 1'b1;
      end
      nibble_exchange_op:
        res.result = {file_val[3:0], file_val[7:4]};
      xor_literal_acc_op:
      begin
        res.result   = acc ^ lit;
        res.upd_zero = 1'b1;
      end
      return_op, powerdown_op, direction_load_op:
        res.result = '0;
    endcase
    res.zero = (res.result == '0);
  end

endmodule : bce_alu

/* bce_exec_asserts.sv */
// Purpose: port checks of the instruction execution unit
// Assumes: CLK_EN gates every instruction take
// Notes:   bound into bce_exec at the foot
module bce_asserts
  import bce_pkg::*;
#(
  parameter int PC_W  = 11,
  parameter int PRE_W = 8
)
(
  input wire logic              CORE_CLK,
  input wire logic              RESET_N,
  input wire logic              CLK_EN,
  input wire logic              INSTR_VALID,
  input wire bce_instr_t        INSTR,
  input wire logic [DATA_W-1:0] FILE_RDATA,
  input wire logic [PC_W-1:0]   STACK_TOP,
  input wire logic              WAKE,
  input wire logic              READY,
  input wire logic              PC_LOAD,
  input wire logic [PC_W-1:0]   PC_VALUE,
  input wire logic              STACK_POP,
  input wire logic              FILE_WE,
  input wire logic [FILE_W-1:0] FILE_WADDR,
  input wire logic [DATA_W-1:0] FILE_WDATA,
  input wire logic              OSC_STOP,
  input wire logic [DATA_W-1:0] DIR1,
  input wire logic [DATA_W-1:0] DIR2
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  logic tk;
  assign tk = CLK_EN && INSTR_VALID && READY;
  sequence s_ret;
    tk && INSTR.op == return_op;
  endsequence
  sequence s_sleep;
    tk && INSTR.op == powerdown_op;
  endsequence
  property p_ret_pc;
    s_ret |=> PC_LOAD && STACK_POP && PC_VALUE == $past(STACK_TOP);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return load");
  property p_ret_two;
    s_ret |=> !READY ##1 (READY || !$past(CLK_EN));
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return gap");
  property p_single;
    tk && !(INSTR.op inside {return_op, powerdown_op}) |=> READY && !PC_LOAD;
  endproperty
  a_single: assert property (p_single) else $error("one cycle op");
  property p_rotl;
    tk && INSTR.op == rotate_left_carry_op && INSTR.dest
      |=> FILE_WE && FILE_WDATA[7:1] == $past(FILE_RDATA[6:0]);
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate left");
  property p_rotr;
    tk && INSTR.op == rotate_right_carry_op && INSTR.dest
      |=> FILE_WE && FILE_WDATA[6:0] == $past(FILE_RDATA[7:1]);
  endproperty
  a_rotr: assert property (p_rotr) else $error("rotate right");
  property p_swap;
    tk && INSTR.op == nibble_exchange_op && INSTR.dest |=> FILE_WE
      && FILE_WDATA == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])}
      && FILE_WADDR == $past(INSTR.file);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap");
  property p_acc_dest;
    tk && !INSTR.dest && INSTR.op inside {rotate_left_carry_op,
      rotate_right_carry_op, subtract_acc_from_file_op,
      nibble_exchange_op} |=> !FILE_WE;
  endproperty
  a_acc_dest: assert property (p_acc_dest) else $error("dest acc");
  property p_sleep_entry;
    s_sleep |=> OSC_STOP && !READY;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep");
  property p_asleep;
    CLK_EN && OSC_STOP && !WAKE |=> OSC_STOP && !READY;
  endproperty
  a_asleep: assert property (p_asleep) else $error("sleep hold");
  property p_wake;
    CLK_EN && OSC_STOP && WAKE |=> !OSC_STOP && READY;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up");
  property p_dir;
    tk && INSTR.op == direction_load_op && INSTR.file == DIR_SEL_FIRST
      |=> $stable(DIR1) && $stable(DIR2) && !FILE_WE;
  endproperty
  a_dir: assert property (p_dir) else $error("direction load");
endmodule : bce_asserts

bind bce_exec bce_asserts #(.PC_W(PC_W), .PRE_W(PRE_W)) u_chk (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
  .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .FILE_RDATA(FILE_RDATA),
  .STACK_TOP(STACK_TOP), .WAKE(WAKE), .READY(READY), .PC_LOAD(PC_LOAD),
  .PC_VALUE(PC_VALUE), .STACK_POP(STACK_POP), .FILE_WE(FILE_WE),
  .FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA), .OSC_STOP(OSC_STOP),
  .DIR1(DIR1), .DIR2(DIR2));

/* bce_exec_tb_top.sv */
// Purpose: self-checking bench of the instruction execution unit
// Assumes: flags read back over the software port
// Notes:   prescaler shortened to 4 bits
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module bce_exec_tb_top;
  import bce_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK = 0, RESET_N = 0, CLK_EN = 1, INSTR_VALID = 0;
  logic WDT_TICK = 0, WAKE = 0, REG_WR = 0, REG_RD = 0;
  bce_instr_t  INSTR = '0;
  logic [7:0]  FILE_RDATA = '0, REG_WDATA = '0;
  logic [10:0] STACK_TOP = '0, PC_VALUE;
  logic [3:0]  REG_ADDR = '0;
  logic [7:0]  REG_RDATA, FILE_WDATA, DIR0, DIR1, DIR2;
  logic [4:0]  FILE_WADDR;
  logic        READY, PC_LOAD, STACK_POP, FILE_WE, OSC_STOP;
  int          errors = 0, checked = 0, cyc = 0;
  always #25 CORE_CLK = ~CORE_CLK;
  bce_exec #(.PC_W(11), .PRE_W(4)) dut (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
    .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .FILE_RDATA(FILE_RDATA),
    .STACK_TOP(STACK_TOP), .WDT_TICK(WDT_TICK), .WAKE(WAKE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .READY(READY),
    .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .STACK_POP(STACK_POP),
    .FILE_WE(FILE_WE), .FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA),
    .OSC_STOP(OSC_STOP), .DIR0(DIR0), .DIR1(DIR1), .DIR2(DIR2));
  task wrap_up;
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 0;
  endtask : wr
  // masked read-back compare
  task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge CORE_CLK);
    REG_RD <= 1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 0;
    #1 `CHK("reg", e, REG_RDATA & m)
  endtask : rd
  task ex(input bce_op_t o, input logic [4:0] f, input logic d,
          input logic [7:0] k, input logic [7:0] v);
    @(posedge CORE_CLK);
    INSTR_VALID <= 1;
    INSTR <= '{o, f, d, k};
    FILE_RDATA <= v;
    @(posedge CORE_CLK);
    INSTR_VALID <= 0;
    #1;
  endtask : ex
  task t_ret;
    #1 `CHK("dir0", RST_DIR, DIR0)
    CLK_EN <= 0;
    ex(return_op, 5'h00, 1'b0, 8'h00, 8'h00);
    `CHK("frozen", 1'b0, PC_LOAD)
    CLK_EN <= 1;
    STACK_TOP <= 11'h5a3;
    ex(return_op, 5'h00, 1'b0, 8'h00, 8'h00);
    `CHK("pc", 11'h5a3, PC_VALUE)
    `CHK("pop", 1'b1, STACK_POP)
    `CHK("ready", 1'b0, READY)
    @(posedge CORE_CLK);
    #1 `CHK("ready", 1'b1, READY)
  endtask : t_ret
  task t_alu;
    wr(OFS_STATUS, 8'h05);
    ex(rotate_left_carry_op, 5'h1f, 1'b1, 8'h00, 8'h81);
    `CHK("rotl", 8'h03, FILE_WDATA)
    `CHK("addr", 5'h1f, FILE_WADDR)
    rd(OFS_STATUS, 8'h07, 8'h05);
    ex(rotate_right_carry_op, 5'h00, 1'b0, 8'h00, 8'h01);
    rd(OFS_ACC, 8'hff, 8'h80);
    rd(OFS_STATUS, 8'h07, 8'h05);
    ex(rotate_right_carry_op, 5'h04, 1'b1, 8'h00, 8'h02);
    `CHK("rotr", 8'h81, FILE_WDATA)
    wr(OFS_ACC, 8'h05);
    ex(subtract_acc_from_file_op, 5'h02, 1'b1, 8'h00, 8'h03);
    `CHK("sub", 8'hfe, FILE_WDATA)
    rd(OFS_STATUS, 8'h07, 8'h00);
    wr(OFS_ACC, 8'h10);
    ex(subtract_acc_from_file_op, 5'h02, 1'b0, 8'h00, 8'h10);
    rd(OFS_ACC, 8'hff, 8'h00);
    rd(OFS_STATUS, 8'h07, 8'h07);
    wr(OFS_STATUS, 8'h00);
    ex(nibble_exchange_op, 5'h03, 1'b0, 8'h00, 8'ha5);
    rd(OFS_ACC, 8'hff, 8'h5a);
    rd(OFS_STATUS, 8'h07, 8'h00);
    ex(nibble_exchange_op, 5'h03, 1'b1, 8'h00, 8'h3c);
    `CHK("nibble_exchange_op", 8'hc3, FILE_WDATA)
    ex(xor_literal_acc_op, 5'h00, 1'b0, 8'h5a, 8'h00);
    rd(OFS_STATUS, 8'h04, 8'h04);
    ex(xor_literal_acc_op, 5'h00, 1'b0, 8'hff, 8'h00);
    rd(OFS_ACC, 8'hff, 8'hff);
    rd(OFS_STATUS, 8'h04, 8'h00);
  endtask : t_alu
  task t_dir;
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_ACC, 8'(8'h30 + i));
      ex(direction_load_op, 5'(6 + i), 1'b0, 8'h00, 8'h00);
    end
    wr(OFS_ACC, 8'hee);
    ex(direction_load_op, 5'h09, 1'b0, 8'h00, 8'h00);
    `CHK("dir", 24'h303132, {DIR0, DIR1, DIR2})
  endtask : t_dir
  task t_sleep;
    WDT_TICK <= 1;
    repeat (20) @(posedge CORE_CLK);
    WDT_TICK <= 0;
    wr(OFS_STATUS, 8'h80);
    ex(powerdown_op, 5'h00, 1'b0, 8'h00, 8'h00);
    `CHK("stop", 1'b1, OSC_STOP)
    rd(OFS_STATUS, 8'h9f, 8'h90);
    rd(OFS_WDOG, 8'hff, 8'h00);
    rd(OFS_PRE, 8'hff, 8'h00);
    ex(xor_literal_acc_op, 5'h00, 1'b0, 8'h0f, 8'h00);
    @(posedge CORE_CLK);
    WAKE <= 1;
    @(posedge CORE_CLK);
    WAKE <= 0;
    #1 `CHK("run", 2'b01, {OSC_STOP, READY})
    rd(OFS_ACC, 8'hff, 8'hee);
  endtask : t_sleep
  always @(posedge CORE_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      errors++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (6) @(posedge CORE_CLK);
    RESET_N <= 1;
    t_ret;
    t_alu;
    t_dir;
    t_sleep;
    wrap_up;
  end
endmodule : bce_exec_tb_top
